// *** logic/lsfr_cfg.svh ***
// lsfr_cfg.svh: numeric constants of the limit-switch fault reaction
// assumes inclusion by bare name from the fault reaction design module
`ifndef LSFR_CFG_SVH
`define LSFR_CFG_SVH
`define LSFR_IDX_OPTION 16'h3701
`define LSFR_IDX_HWINFO 16'h4012
`define LSFR_IDX_HWCFG 16'h4013
`define LSFR_SUB_COUNT 8'h00
`define LSFR_SUB_FIRST 8'h01
`define LSFR_ARRAY_ENTRIES 32'h0000_0001
`define LSFR_OPTION_RESET 16'hFFFF
`define LSFR_HWCFG_RESET 32'h0000_0000
`define LSFR_STATUS_WARN_BIT 7
`define LSFR_OPT_DISCARD 16'hFFFE
`define LSFR_OPT_NOTE 16'hFFFF
`define LSFR_OPT_OFF 16'h0000
`define LSFR_OPT_SLOW_SOD 16'h0001
`define LSFR_OPT_QUICK_SOD 16'h0002
`define LSFR_OPT_SLOW_QSA 16'h0005
`define LSFR_OPT_QUICK_QSA 16'h0006
`endif

// *** logic/lsfr_pkg.sv ***
// lsfr_pkg: types shared by the limit-switch fault reaction modules
// assumes lsfr_cfg.svh is on the include path
package lsfr_pkg;
    // drive states seen by this block
    typedef enum logic [1:0] {
        LSFR_SOD  = 2'b00,
        LSFR_OPEN = 2'b01,
        LSFR_RAMP = 2'b10,
        LSFR_QSA  = 2'b11
    } lsfr_state_t;
endpackage

// *** logic/lsfr_sync.sv ***
// lsfr_sync: two-stage synchroniser for asynchronous pin levels
// assumes the pins are quasi-static compared with clk
`timescale 1ns/1ps
`default_nettype none
module lsfr_sync
    import lsfr_pkg::*;
#(
    parameter int WIDTH = 2
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] pinLevel,
    output logic [WIDTH-1:0] syncLevel
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    if (WIDTH < 1)
    begin : g_bad_width
        $error("lsfr_sync: WIDTH must be at least 1");
    end

    // first stage feeds only the second stage
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= pinLevel;
            sync_q <= meta_q;
        end
    end

    assign syncLevel = sync_q;
endmodule // lsfr_sync
`default_nettype wire

// *** logic/lsfr_ramp.sv ***
// lsfr_ramp: brings a speed magnitude down to zero by a fixed step a cycle
// assumes start is a one-cycle pulse and step is non-zero
`timescale 1ns/1ps
`default_nettype none
module lsfr_ramp
    import lsfr_pkg::*;
#(
    parameter int SPEED_W = 16
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [SPEED_W-1:0] initSpeed,
    input wire logic [SPEED_W-1:0] step,
    output logic [SPEED_W-1:0] speed,
    output logic busy,
    output logic done
);
    logic [SPEED_W-1:0] speed_q;
    logic busy_q;
    logic done_q;
    // a zero step would never finish, so it is treated as one
    wire logic [SPEED_W-1:0] effStep = (step == '0) ? SPEED_W'(1) : step;
    wire logic lastStep = (speed_q <= effStep);

    if (SPEED_W < 2)
    begin : g_bad_width
        $error("lsfr_ramp: SPEED_W too small");
    end

    // load on start, then step down until the last step lands on zero
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            speed_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            done_q <= busy_q && lastStep;
            if (start)
            begin
                speed_q <= initSpeed;
                busy_q <= 1'b1;
            end
            else if (busy_q)
            begin
                speed_q <= lastStep ? '0 : speed_q - effStep;
                busy_q <= !lastStep;
            end
        end
    end

    assign speed = speed_q;
    assign busy = busy_q;
    assign done = done_q;
endmodule // lsfr_ramp
`default_nettype wire

// *** logic/lsfr_limit_switch_fault_reaction.sv ***
// lsfr_limit_switch_fault_reaction: fault reaction to a passed limit switch,
// with the option entry and hardware-information entries of the dictionary
// assumes the master's dictionary access arrives as a one-cycle request on clk
//
// Behaviour
// - passing a limit switch sets status bit 7 and runs the chosen reaction, stopping ones only from operation enabled
// - option -2: no stopping, discard the recorded limit switch position
// - option -1: no stopping, but record the position where switch was reached
// - option value resets to -1
// - option 0: driver off at once, no ramp, enter switch on disabled
// - option 1 slow ramp, 2 quick ramp, then switch on disabled
// - option 5 slow ramp, 6 quick ramp, then quick stop active, motor energised
// - after 5 or 6, master may go from quick stop active to operation enabled
// - read-only entry reports attached EEPROM size in bytes
// - EEPROM size entry reads zero when no EEPROM is attached
`include "lsfr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module lsfr_limit_switch_fault_reaction
    import lsfr_pkg::*;
#(
    parameter int SPEED_W = 16,
    parameter int POS_W = 32
)
(
    input wire logic clk,
    input wire logic rst,
    // limit switch pins and drive feedback
    input wire logic limitPosPin,
    input wire logic limitNegPin,
    input wire logic [POS_W-1:0] actualPosition,
    input wire logic [SPEED_W-1:0] demandSpeed,
    input wire logic [SPEED_W-1:0] slowDownStep,
    input wire logic [SPEED_W-1:0] quickStopStep,
    input wire logic [31:0] eepromSizeStrap,
    // master state commands
    input wire logic cmdEnableOperation,
    input wire logic cmdDisable,
    input wire logic cmdClearWarning,
    // dictionary access
    input wire logic odReq,
    input wire logic odWrite,
    input wire logic [15:0] odIndex,
    input wire logic [7:0] odSubIndex,
    input wire logic [31:0] odWriteData,
    output logic odAck,
    output logic odAbort,
    output logic [31:0] odReadData,
    // drive side
    output logic [15:0] statusWord,
    output logic driverEnable,
    output logic [SPEED_W-1:0] speedCommand,
    output lsfr_state_t driveState,
    output logic [POS_W-1:0] limitPosition,
    output logic limitPositionValid
);
    // ==========================================================
    // elaboration checks
    // ==========================================================
    if (SPEED_W < 2 || SPEED_W > 32)
    begin : g_bad_speed_w
        $error("lsfr: SPEED_W out of range");
    end
    if (POS_W < 1 || POS_W > 64)
    begin : g_bad_pos_w
        $error("lsfr: POS_W out of range");
    end

    // ==========================================================
    // limit switch input and event
    // ==========================================================
    logic [1:0] limitSync;
    logic limitSeen_q;
    wire logic limitActive = |limitSync;
    wire logic limitEvent = limitActive && !limitSeen_q;

    lsfr_sync #(.WIDTH(2)) uSync
    (
        .clk(clk),
        .rst(rst),
        .pinLevel({limitNegPin, limitPosPin}),
        .syncLevel(limitSync)
    );

    // one event per arrival on a switch, not one per cycle held on it
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            limitSeen_q <= 1'b0;
        else
            limitSeen_q <= limitActive;
    end

    // ==========================================================
    // dictionary decode
    // ==========================================================
    logic [15:0] option_q;
    logic [31:0] hwSetup_q;
    logic [31:0] eepromSize_q;
    logic strapTaken_q;

    wire logic hitOption = (odIndex == `LSFR_IDX_OPTION) && (odSubIndex == `LSFR_SUB_COUNT);
    wire logic hitInfo = (odIndex == `LSFR_IDX_HWINFO);
    wire logic hitCfg = (odIndex == `LSFR_IDX_HWCFG);
    wire logic subCount = (odSubIndex == `LSFR_SUB_COUNT);
    wire logic subFirst = (odSubIndex == `LSFR_SUB_FIRST);
    wire logic readable = hitOption || ((hitInfo || hitCfg) && (subCount || subFirst));
    wire logic writable = hitOption || (hitCfg && subFirst);
    wire logic accessOk = odWrite ? writable : readable;
    wire logic writeOption = odReq && odWrite && hitOption;
    wire logic writeHwSetup = odReq && odWrite && hitCfg && subFirst;
    wire logic [31:0] readMux =
        hitOption ? {{16{option_q[15]}}, option_q} :
        subCount ? `LSFR_ARRAY_ENTRIES :
        hitInfo ? eepromSize_q :
        hitCfg ? hwSetup_q : 32'h0000_0000;

    // ==========================================================
    // option decode
    // ==========================================================
    // the stored 16-bit value is compared whole, so codes like
    // 16'h0105 never alias onto a defined reaction
    wire logic optDiscard = (option_q == `LSFR_OPT_DISCARD);
    wire logic optNote = (option_q == `LSFR_OPT_NOTE);
    wire logic optOff = (option_q == `LSFR_OPT_OFF);
    wire logic optSlowSod = (option_q == `LSFR_OPT_SLOW_SOD);
    wire logic optQuickSod = (option_q == `LSFR_OPT_QUICK_SOD);
    wire logic optSlowQsa = (option_q == `LSFR_OPT_SLOW_QSA);
    wire logic optQuickQsa = (option_q == `LSFR_OPT_QUICK_QSA);
    wire logic optRamp = optSlowSod || optQuickSod || optSlowQsa || optQuickQsa;
    wire logic optQuick = optQuickSod || optQuickQsa;
    wire logic optToQsa = optSlowQsa || optQuickQsa;

    // ==========================================================
    // dictionary registers
    // ==========================================================
    // reserved values are stored as written but later select no reaction
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            option_q <= `LSFR_OPTION_RESET;
            hwSetup_q <= `LSFR_HWCFG_RESET;
        end
        else
        begin
            if (writeOption)
                option_q <= odWriteData[15:0];
            if (writeHwSetup)
                hwSetup_q <= odWriteData;
        end
    end

    // the size strap is caught once after reset release, never under reset
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            eepromSize_q <= 32'h0000_0000;
            strapTaken_q <= 1'b0;
        end
        else if (!strapTaken_q)
        begin
            eepromSize_q <= eepromSizeStrap;
            strapTaken_q <= 1'b1;
        end
    end

    // answer one cycle after each request
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            odAck <= 1'b0;
            odAbort <= 1'b0;
            odReadData <= 32'h0000_0000;
        end
        else
        begin
            odAck <= odReq;
            odAbort <= odReq && !accessOk;
            if (odReq && !odWrite && readable)
                odReadData <= readMux;
        end
    end

    // ==========================================================
    // braking ramp
    // ==========================================================
    logic [SPEED_W-1:0] rampSpeed;
    logic rampDone;
    lsfr_state_t state_q;
    lsfr_state_t state_d;
    logic toQsa_q;
    wire logic inMotion = (state_q == LSFR_OPEN);
    wire logic reactRamp = limitEvent && inMotion && optRamp;
    wire logic reactOff = limitEvent && inMotion && optOff;

    lsfr_ramp #(.SPEED_W(SPEED_W)) uRamp
    (
        .clk(clk),
        .rst(rst),
        .start(reactRamp),
        .initSpeed(speedCommand),
        .step(optQuick ? quickStopStep : slowDownStep),
        .speed(rampSpeed),
        .busy(),
        .done(rampDone)
    );

    // ==========================================================
    // drive state machine
    // ==========================================================
    // stopping reactions only matter while the drive is running
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            LSFR_SOD:
                if (cmdEnableOperation)
                    state_d = LSFR_OPEN;
            LSFR_OPEN:
                if (reactOff || cmdDisable)
                    state_d = LSFR_SOD;
                else if (reactRamp)
                    state_d = LSFR_RAMP;
            LSFR_RAMP:
                if (cmdDisable)
                    state_d = LSFR_SOD;
                else if (rampDone)
                    state_d = toQsa_q ? LSFR_QSA : LSFR_SOD;
            LSFR_QSA:
                if (cmdDisable)
                    state_d = LSFR_SOD;
                else if (cmdEnableOperation)
                    state_d = LSFR_OPEN;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= LSFR_SOD;
            toQsa_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            if (reactRamp)
                toQsa_q <= optToQsa;
        end
    end

    // ==========================================================
    // drive outputs
    // ==========================================================
    // quick stop active keeps the bridge energised at zero speed
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            driverEnable <= 1'b0;
            speedCommand <= '0;
            driveState <= LSFR_SOD;
        end
        else
        begin
            driverEnable <= (state_d != LSFR_SOD);
            driveState <= state_d;
            unique case (state_d)
                LSFR_OPEN: speedCommand <= demandSpeed;
                LSFR_RAMP: speedCommand <= reactRamp ? speedCommand : rampSpeed;
                LSFR_SOD, LSFR_QSA: speedCommand <= '0;
            endcase
        end
    end

    // ==========================================================
    // warning bit and noted position
    // ==========================================================
    // a new limit event wins over a clear in the same cycle
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            statusWord <= 16'h0000;
        else if (limitEvent)
            statusWord[`LSFR_STATUS_WARN_BIT] <= 1'b1;
        else if (cmdClearWarning)
            statusWord[`LSFR_STATUS_WARN_BIT] <= 1'b0;
    end

    // reserved codes leave the noted position untouched
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            limitPosition <= '0;
            limitPositionValid <= 1'b0;
        end
        else if (limitEvent && optDiscard)
        begin
            limitPosition <= '0;
            limitPositionValid <= 1'b0;
        end
        else if (limitEvent && !optDiscard && (optNote || optOff || optRamp))
        begin
            limitPosition <= actualPosition;
            limitPositionValid <= 1'b1;
        end
    end
endmodule // lsfr_limit_switch_fault_reaction
`default_nettype wire

// *** verif/lsfr_checker.sv ***
// lsfr_checker: port-level assertions for the fault reaction block
// assumes it is bound to lsfr_limit_switch_fault_reaction
`timescale 1ns/1ps
`default_nettype none
module lsfr_checker
    import lsfr_pkg::*;
#(
    parameter int SPEED_W = 16
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic limitPosPin,
    input wire logic limitNegPin,
    input wire logic [31:0] eepromSizeStrap,
    input wire logic cmdEnableOperation,
    input wire logic cmdDisable,
    input wire logic odReq,
    input wire logic odWrite,
    input wire logic [15:0] odIndex,
    input wire logic [7:0] odSubIndex,
    input wire logic odAck,
    input wire logic odAbort,
    input wire logic [31:0] odReadData,
    input wire logic [15:0] statusWord,
    input wire logic driverEnable,
    input wire logic [SPEED_W-1:0] speedCommand,
    input wire lsfr_state_t driveState
);
    // ====================================
    // checks on clk, idle while rst is high
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // answer exactly one cycle after a request, and never without one
    property p_ack; odReq |=> odAck; endproperty
    a_ack: assert property (p_ack) else $error("request not answered");
    property p_quiet; !odReq |=> !odAck; endproperty
    a_quiet: assert property (p_quiet) else $error("answer without request");
    property p_abt; odAbort |-> odAck; endproperty
    a_abt: assert property (p_abt) else $error("refusal without answer");
    // pin rise reaches the warning bit after sync and edge detect
    property p_warn; $rose(limitPosPin | limitNegPin) |-> ##[1:5] statusWord[7]; endproperty
    a_warn: assert property (p_warn) else $error("warning bit not set");
    property p_en; driverEnable == (driveState != LSFR_SOD); endproperty
    a_en: assert property (p_en) else $error("driver enable off state");
    property p_dis; cmdDisable |=> driveState == LSFR_SOD && !driverEnable; endproperty
    a_dis: assert property (p_dis) else $error("disable not taken");
    // speed never rises while braking
    property p_ramp; driveState == LSFR_RAMP |=> speedCommand <= $past(speedCommand); endproperty
    a_ramp: assert property (p_ramp) else $error("speed rose in ramp");
    property p_qsa; driveState == LSFR_QSA |-> driverEnable && speedCommand == '0; endproperty
    a_qsa: assert property (p_qsa) else $error("quick stop not held");
    property p_back;
        driveState == LSFR_QSA && cmdEnableOperation && !cmdDisable |=> driveState == LSFR_OPEN;
    endproperty
    a_back: assert property (p_back) else $error("no return from quick stop");
    property p_size;
        odReq && !odWrite && odIndex == 16'h4012 && odSubIndex == 8'h01
            |=> !odAbort && odReadData == eepromSizeStrap;
    endproperty
    a_size: assert property (p_size) else $error("eeprom size wrong");
    property p_ro; odReq && odWrite && odIndex == 16'h4012 |=> odAbort; endproperty
    a_ro: assert property (p_ro) else $error("hw info write taken");
endmodule // lsfr_checker

bind lsfr_limit_switch_fault_reaction lsfr_checker #(.SPEED_W(SPEED_W)) u_chk (
    .clk, .rst, .limitPosPin, .limitNegPin, .eepromSizeStrap, .cmdEnableOperation,
    .cmdDisable, .odReq, .odWrite, .odIndex, .odSubIndex, .odAck, .odAbort,
    .odReadData, .statusWord, .driverEnable, .speedCommand, .driveState
);
`default_nettype wire

// *** verif/lsfr_master.sv ***
// lsfr_master: fieldbus master model for dictionary access and state commands
// assumes its tasks are called from tb; outputs change just after rising edges
`timescale 1ns/1ps
`default_nettype none
module lsfr_master
(
    input wire logic clk,
    output logic odReq,
    output logic odWrite,
    output logic [15:0] odIndex,
    output logic [7:0] odSubIndex,
    output logic [31:0] odWriteData,
    output logic cmdEnableOperation,
    output logic cmdDisable,
    output logic cmdClearWarning
);
    // ====================================
    // idle levels at time zero
    initial
    begin
        {odReq, odWrite, cmdEnableOperation, cmdDisable, cmdClearWarning} = 5'h00;
        {odIndex, odSubIndex, odWriteData} = 56'h0;
    end

    // one-cycle request; address and data are scrambled afterwards so
    // a design that samples them late never sees the old values
    task automatic access(input logic w, input logic [15:0] i, input logic [7:0] s,
        input logic [31:0] d);
    begin
        @(posedge clk);
        odReq <= 1'b1;
        odWrite <= w;
        {odIndex, odSubIndex, odWriteData} <= {i, s, d};
        @(posedge clk);
        odReq <= 1'b0;
        odWrite <= ~w;
        {odIndex, odSubIndex, odWriteData} <= ~{i, s, d};
    end
    endtask

    // state command pulse: 0 disable, 1 enable operation, 2 clear warning
    task automatic pulse(input logic [1:0] c);
    begin
        @(posedge clk);
        cmdDisable <= c == 2'h0;
        cmdEnableOperation <= c == 2'h1;
        cmdClearWarning <= c == 2'h2;
        @(posedge clk);
        {cmdEnableOperation, cmdDisable, cmdClearWarning} <= 3'h0;
    end
    endtask
endmodule // lsfr_master
`default_nettype wire

// *** verif/tb.sv ***
// tb: self-checking bench for the limit-switch fault reaction block
// assumes lsfr_master as dictionary partner and lsfr_checker bound in
`timescale 1ns/1ps
`default_nettype none
module tb
    import lsfr_pkg::*;
;
    logic clk, rst, limitPosPin, limitNegPin, odReq, odWrite, odAck, odAbort;
    logic cmdEnableOperation, cmdDisable, cmdClearWarning, driverEnable, limitPositionValid;
    logic [15:0] demandSpeed, slowDownStep, quickStopStep, odIndex, statusWord, speedCommand;
    logic [31:0] actualPosition, eepromSizeStrap, odWriteData, odReadData, limitPosition;
    logic [7:0] odSubIndex;
    lsfr_state_t driveState;
    logic [33:0] expQ[$];
    logic [33:0] e;
    logic [31:0] strap;
    logic [15:0] codes[9] = '{16'hFFFE, 16'hFFFF, 16'h0000, 16'h0001, 16'h0002, 16'h0005,
        16'h0006, 16'h0003, 16'h8000};
    int seed;
    int err_total = 0;
    int n_checks = 0;

    lsfr_limit_switch_fault_reaction u_dut (
        .clk, .rst, .limitPosPin, .limitNegPin, .actualPosition, .demandSpeed, .slowDownStep,
        .quickStopStep, .eepromSizeStrap, .cmdEnableOperation, .cmdDisable, .cmdClearWarning,
        .odReq, .odWrite, .odIndex, .odSubIndex, .odWriteData, .odAck, .odAbort, .odReadData,
        .statusWord, .driverEnable, .speedCommand, .driveState, .limitPosition,
        .limitPositionValid
    );
    lsfr_master u_mst (
        .clk, .odReq, .odWrite, .odIndex, .odSubIndex, .odWriteData, .cmdEnableOperation,
        .cmdDisable, .cmdClearWarning
    );

    // ====================================
    // clock, 8 ns period
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask

    task automatic complete_run();
    begin
        if (err_total == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    end
    endtask

    task automatic do_reset(input logic [31:0] s);
    begin
        @(posedge clk);
        rst <= 1'b1;
        eepromSizeStrap <= s;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
    end
    endtask

    // note the expected answer, then let the master ask
    task automatic od(input logic w, input logic [15:0] i, input logic [7:0] s,
        input logic [31:0] d, input logic ab, input logic [31:0] ex);
    begin
        expQ.push_back({~w & ~ab, ab, ex});
        u_mst.access(w, i, s, d);
    end
    endtask

    // answers are matched in order; read data only on accepted reads
    always @(negedge clk)
    begin
        if (odAck === 1'b1)
        begin
            chk(32'(expQ.size() != 0), 32'h1);
            e = (expQ.size() > 0) ? expQ.pop_front() : 34'h1_0000_0000;
            chk({31'h0, odAbort}, {31'h0, e[32]});
            if (e[33])
                chk(odReadData, e[31:0]);
        end
    end

    // one limit event under option c, starting from operation enabled
    task automatic react(input logic [15:0] c, input logic neg);
        int n;
        logic ok;
        logic rsv;
        logic pv;
        logic [31:0] ps;
        logic [31:0] p;
        logic [15:0] sp;
        lsfr_state_t st;
    begin
        n = 0;
        p = $random(seed);
        sp = 16'h0010 + 16'($random(seed) & 32'h3F);
        pv = limitPositionValid;
        ps = limitPosition;
        @(posedge clk);
        actualPosition <= p;
        demandSpeed <= sp;
        slowDownStep <= 16'h0001;
        quickStopStep <= sp;
        od(1'b1, 16'h3701, 8'h00, {16'h0, c}, 1'b0, 32'h0);
        od(1'b0, 16'h3701, 8'h00, 32'h0, 1'b0, {{16{c[15]}}, c});
        u_mst.pulse(2'h0);
        u_mst.pulse(2'h1);
        @(posedge clk);
        limitNegPin <= neg;
        limitPosPin <= ~neg;
        for (int k = 0; k < 200; k++)
        begin
            @(negedge clk);
            n += int'(driveState === LSFR_RAMP);
        end
        rsv = !(c inside {16'hFFFE, 16'hFFFF, 16'h0, 16'h1, 16'h2, 16'h5, 16'h6});
        st = (c inside {16'h0, 16'h1, 16'h2}) ? LSFR_SOD : (c inside {16'h5, 16'h6}) ?
            LSFR_QSA : LSFR_OPEN;
        ok = (c inside {16'h1, 16'h5}) ? n >= sp : (c inside {16'h2, 16'h6}) ?
            n inside {[1:3]} : n == 0;
        chk({16'h0, statusWord}, 32'h0000_0080);
        chk(limitPosition, rsv ? ps : (c == 16'hFFFE ? 32'h0 : p));
        chk({31'h0, limitPositionValid}, {31'h0, rsv ? pv : c != 16'hFFFE});
        chk({30'h0, driveState}, {30'h0, st});
        chk({31'h0, driverEnable}, {31'h0, st != LSFR_SOD});
        chk({16'h0, speedCommand}, st == LSFR_OPEN ? {16'h0, sp} : 32'h0);
        chk({31'h0, ok}, 32'h1);
        if (st == LSFR_QSA)
        begin
            u_mst.pulse(2'h1);
            @(negedge clk);
            chk({30'h0, driveState}, {30'h0, LSFR_OPEN});
        end
        @(posedge clk);
        {limitPosPin, limitNegPin} <= 2'h0;
        u_mst.pulse(2'h2);
        @(negedge clk);
        chk({16'h0, statusWord}, 32'h0);
    end
    endtask

    // main sequence
    initial
    begin
        seed = 51118;
        {rst, limitPosPin, limitNegPin} = 3'h4;
        {actualPosition, eepromSizeStrap} = 64'h0;
        {demandSpeed, slowDownStep, quickStopStep} = 48'h0000_0001_0001;
        do_reset(32'h0);
        od(1'b0, 16'h4012, 8'h01, 32'h0, 1'b0, 32'h0);
        strap = $random(seed);
        do_reset(strap);
        @(negedge clk);
        chk({30'h0, driveState}, {30'h0, LSFR_SOD});
        od(1'b0, 16'h3701, 8'h00, 32'h0, 1'b0, 32'hFFFF_FFFF);
        od(1'b0, 16'h4012, 8'h00, 32'h0, 1'b0, 32'h1);
        od(1'b0, 16'h4012, 8'h01, 32'h0, 1'b0, strap);
        od(1'b1, 16'h4012, 8'h01, 32'h5A, 1'b1, 32'h0);
        od(1'b0, 16'h4013, 8'h01, 32'h0, 1'b0, 32'h0);
        od(1'b1, 16'h4013, 8'h01, ~strap, 1'b0, 32'h0);
        od(1'b0, 16'h4013, 8'h01, 32'h0, 1'b0, ~strap);
        od(1'b0, 16'h3701, 8'h01, 32'h0, 1'b1, 32'h0);
        od(1'b0, 16'h4014, 8'h00, 32'h0, 1'b1, 32'h0);
        foreach (codes[i])
            react(codes[i], i[0]);
        repeat (4) @(posedge clk);
        chk(32'(expQ.size()), 32'h0);
        complete_run();
    end

    // watchdog well beyond the expected run of about 2000 cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        complete_run();
    end
endmodule // tb
`default_nettype wire
